// ### src/rcw_pkg.sv
/*
  Constants, field layouts and carrier types of the runaway-code watchdog.
  Assumes one 100 MHz system clock with the crystal rate given as an enable.
*/
// Behaviour
// - Six-bit counter advances on carry of a twelve-bit crystal-clock prescaler.
// - Overflow resets after 2^13-2^4 or 2^18-2^4 crystal cycles by rate choice.
// - Any write to the service location clears counter and prescaler stages 4 to 12.
// - Expiry holds reset pin low 32 crystal cycles and sets watchdog cause bit.
// - In monitor mode, test voltage on reset or interrupt pin disables the watchdog.
// - In break state, test voltage on the reset pin disables the watchdog.
// - Stop instruction clears the prescaler.
// - Reading the service location returns the reset vector low byte, not state.
// - Power-on logic clears the prescaler 4096 crystal cycles after power-up.
// - A reset vector fetch clears the prescaler.
// - Disable input follows the option disable bit and keeps the watchdog idle.
// - Long-timeout input follows the option rate bit and picks the period.
// - The watchdog never raises an interrupt request, only a reset; the code also drives WATCHDOG_IRQ from masked expire and service events.
// - Stop mode halts crystal clocking and clears the prescaler until it ends.
// - Counting continues in wait mode.
package rcw_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] RCW_SERVICE_ADDR = 16'hffff;
  localparam logic [15:0] RCW_STATUS_ADDR = 16'h0000;
  localparam logic [15:0] RCW_MASK_ADDR = 16'h0004;
  localparam logic [15:0] RCW_CONFIG_ADDR = 16'h0008;
  localparam logic [15:0] RCW_CAUSE_ADDR = 16'h000c;
  localparam logic [15:0] RCW_COUNT_ADDR = 16'h0010;

  // Event bits in status and mask
  localparam int RCW_EV_EXPIRE = 0;
  localparam int RCW_EV_SERVICE = 1;
  localparam int RCW_EV_WIDTH = 2;

  // Config bits
  localparam int RCW_CFG_DISABLE = 0;
  localparam int RCW_CFG_LONG = 1;
  localparam logic [1:0] RCW_CFG_RESET = 2'h0;

  // Cause register bit
  localparam int RCW_CAUSE_WDOG = 0;

  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int RCW_PRE_W = 12;
  localparam int RCW_CNT_W = 6;
  localparam logic [RCW_PRE_W-1:0] RCW_PRE_KEEP = 12'h007;
  localparam logic [RCW_CNT_W-1:0] RCW_CNT_SHORT_END = 6'h01;
  localparam logic [RCW_CNT_W-1:0] RCW_CNT_LONG_END = 6'h3f;
  localparam logic [RCW_PRE_W-1:0] RCW_PRE_SHORT_TOP = 12'hff0;
  localparam logic [RCW_PRE_W-1:0] RCW_PRE_LONG_TOP = 12'hff0;
  localparam int RCW_PULSE_CYC = 32;
  localparam logic [5:0] RCW_PULSE_LAST = 6'(RCW_PULSE_CYC - 1);
  localparam int RCW_POR_CYC = 4096;
  localparam logic [12:0] RCW_POR_LAST = 13'(RCW_POR_CYC - 1);
  localparam int RCW_SYS_HZ = 100_000_000;
  localparam int RCW_XTAL_HZ = 25_000_000;
  localparam logic [7:0] RCW_VEC_LOW = 8'h00;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic monitor;
    logic brk;
    logic hv_rst;
    logic hv_irq;
    logic stop_mode;
    logic stop_exec;
    logic vec_fetch;
  } rcw_core_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rcw_bus_t;

endpackage

// ### src/rcw_xtal_div.sv
/*
  Fractional divider that produces the crystal clock rate as a one-cycle enable.
  Assumes the system clock is faster than the crystal rate.
*/
`timescale 1ns/10ps
module rcw_xtal_div import rcw_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] acc_q;
  logic [32:0] sum;

  assign sum = {1'b0, acc_q} + 33'(RCW_XTAL_HZ);

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= 32'h0;
      tick <= 1'b0;
    end else if (sum >= 33'(RCW_SYS_HZ)) begin
      acc_q <= 32'(sum - 33'(RCW_SYS_HZ));
      tick <= 1'b1;
    end else begin
      acc_q <= sum[31:0];
      tick <= 1'b0;
    end
  end
endmodule

// ### src/rcw_por_timer.sv
/*
  Power-on delay: pulses once after the set number of crystal ticks.
  Assumes the clear input marks power-up.
*/
`timescale 1ns/10ps
module rcw_por_timer import rcw_pkg::*; (
  input wire logic clk,
  input wire logic por,
  input wire logic tick,
  output logic done
);
  logic [12:0] cnt_q;
  logic run_q;

  always_ff @(posedge clk) begin
    if (por) begin
      cnt_q <= 13'h0;
      run_q <= 1'b1;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (run_q && tick) begin
        if (cnt_q == RCW_POR_LAST) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 13'h1;
        end
      end
    end
  end
endmodule

// ### src/rcw_top.sv
/*
  Runaway-code watchdog: prescaler, counter, reset pulse and register port.
  Assumes synchronous inputs, a power-on pulse on POR and a single-cycle bus.
*/
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module rcw_top import rcw_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic POR,
  input wire logic MONITOR_MODE,
  input wire logic BREAK_STATE,
  input wire logic HV_ON_RESET_PIN,
  input wire logic HV_ON_IRQ_PIN,
  input wire logic STOP_MODE,
  input wire logic STOP_EXEC,
  input wire logic VECTOR_FETCH,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic RESET_PIN_N,
  output logic RESET_PIN_OE,
  output logic WATCHDOG_IRQ,
  output logic [RCW_CNT_W-1:0] COUNT
);

  // ----------------------------------------
  // Input grouping and timing enables
  // ----------------------------------------
  rcw_core_t core;
  rcw_bus_t bus;
  logic xtal_tick;
  logic por_done;

  assign core = '{monitor: MONITOR_MODE, brk: BREAK_STATE, hv_rst: HV_ON_RESET_PIN,
                  hv_irq: HV_ON_IRQ_PIN, stop_mode: STOP_MODE, stop_exec: STOP_EXEC,
                  vec_fetch: VECTOR_FETCH};
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  rcw_xtal_div u_div (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .tick(xtal_tick)
  );

  rcw_por_timer u_por (
    .clk(SYS_CLK),
    .por(POR),
    .tick(xtal_tick),
    .done(por_done)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [1:0] cfg_q;
  logic [RCW_EV_WIDTH-1:0] status_q;
  logic [RCW_EV_WIDTH-1:0] mask_q;
  logic cause_q;
  logic [RCW_PRE_W-1:0] pre_q;
  logic [RCW_CNT_W-1:0] cnt_q;
  logic [5:0] pulse_q;
  logic pulse_on_q;

  logic wd_disable;
  logic wd_long;
  logic hv_off;
  logic active;
  logic service;
  logic pre_clr;
  logic step;
  logic carry;
  logic expire;
  logic [RCW_CNT_W-1:0] cnt_end;
  logic [RCW_PRE_W-1:0] pre_top;

  assign wd_disable = cfg_q[RCW_CFG_DISABLE];
  assign wd_long = cfg_q[RCW_CFG_LONG];
  assign hv_off = (core.monitor && (core.hv_rst || core.hv_irq))
               || (core.brk && core.hv_rst);
  assign active = !wd_disable && !hv_off && !pulse_on_q;
  assign service = bus.wr && (bus.addr == RCW_SERVICE_ADDR);
  assign pre_clr = core.stop_exec || core.stop_mode || por_done
                || core.vec_fetch;
  // Counting halts in stop mode, runs in wait mode
  assign step = xtal_tick && active && !core.stop_mode;
  assign carry = (pre_q == {RCW_PRE_W{1'b1}});
  // Short period ends 2^4 cycles early: counter 1, prescaler top reached
  assign cnt_end = wd_long ? RCW_CNT_LONG_END : RCW_CNT_SHORT_END;
  assign pre_top = wd_long ? RCW_PRE_LONG_TOP : RCW_PRE_SHORT_TOP;
  assign expire = step && (cnt_q == cnt_end) && (pre_q == pre_top - 12'h1);

  // ----------------------------------------
  // Configuration and mask writes
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cfg_q <= RCW_CFG_RESET;
      mask_q <= '0;
    end else if (bus.wr) begin
      if (bus.addr == RCW_CONFIG_ADDR) begin
        cfg_q <= bus.wdata[1:0];
      end
      if (bus.addr == RCW_MASK_ADDR) begin
        mask_q <= bus.wdata[RCW_EV_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (expire) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else begin
      if (service) begin
        cnt_q <= '0;
        pre_q <= pre_q & RCW_PRE_KEEP;
      end else if (pre_clr) begin
        pre_q <= '0;
      end else if (step) begin
        pre_q <= pre_q + 12'h1;
        if (carry) begin
          cnt_q <= cnt_q + 6'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Reset pulse and cause
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pulse_q <= '0;
      pulse_on_q <= 1'b0;
    end else if (expire) begin
      pulse_q <= '0;
      pulse_on_q <= 1'b1;
    end else if (pulse_on_q && xtal_tick) begin
      if (pulse_q == RCW_PULSE_LAST) begin
        pulse_on_q <= 1'b0;
      end else begin
        pulse_q <= pulse_q + 6'h1;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (POR) begin
      cause_q <= 1'b0;
    end else if (expire) begin
      cause_q <= 1'b1;
    end else if (bus.rd && bus.addr == RCW_CAUSE_ADDR) begin
      cause_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Event status, write one to clear
  // ----------------------------------------
  logic [RCW_EV_WIDTH-1:0] ev;
  logic [RCW_EV_WIDTH-1:0] clr;

  assign ev = {service, expire};
  assign clr = (bus.wr && bus.addr == RCW_STATUS_ADDR) ? bus.wdata[RCW_EV_WIDTH-1:0] : '0;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      RESET_PIN_N <= 1'b1;
      RESET_PIN_OE <= 1'b0;
      WATCHDOG_IRQ <= 1'b0;
      COUNT <= '0;
    end else begin
      RESET_PIN_N <= !(pulse_on_q || expire);
      RESET_PIN_OE <= pulse_on_q || expire;
      // Status line for system software, not a processor request
      WATCHDOG_IRQ <= |(((status_q & ~clr) | ev) & mask_q);
      COUNT <= cnt_q;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      RDATA <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        RCW_SERVICE_ADDR: RDATA <= {24'h0, RCW_VEC_LOW};
        RCW_STATUS_ADDR: RDATA <= {30'h0, status_q};
        RCW_MASK_ADDR: RDATA <= {30'h0, mask_q};
        RCW_CONFIG_ADDR: RDATA <= {30'h0, cfg_q};
        RCW_CAUSE_ADDR: RDATA <= {31'h0, cause_q};
        RCW_COUNT_ADDR: RDATA <= {14'h0, cnt_q, pre_q};
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

endmodule

// ### sim/rcw_top_monitor.sv
/* Port assertions for the watchdog top.
   Assumes the bind below attaches it to rcw_top. */
`timescale 1ns/10ps
module rcw_top_monitor import rcw_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic MONITOR_MODE,
  input wire logic BREAK_STATE,
  input wire logic HV_ON_RESET_PIN,
  input wire logic HV_ON_IRQ_PIN,
  input wire logic STOP_MODE,
  input wire logic [15:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic RESET_PIN_N,
  input wire logic RESET_PIN_OE,
  input wire logic [RCW_CNT_W-1:0] COUNT
);
  logic [15:0] low_q;
  // Cycles the reset pin has been low
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || RESET_PIN_N) begin
      low_q <= 16'h0;
    end else begin
      low_q <= low_q + 16'h1;
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  a_pin_enable_pair: assert property (RESET_PIN_OE != RESET_PIN_N)
    else $error("pin enable mismatch");
  a_pulse_width: assert property ($rose(RESET_PIN_N) |-> low_q inside {[126:132]})
    else $error("reset pulse length");
  a_reset_clears: assert property ($fell(SYS_RST) |-> COUNT == '0 && RESET_PIN_N)
    else $error("count after reset");
  a_count_steps: assert property (COUNT != $past(COUNT) |->
    COUNT == $past(COUNT) + 6'h1 || COUNT == '0)
    else $error("count jump");
  a_service_clears: assert property (WR && ADDR == RCW_SERVICE_ADDR |-> ##[1:2] COUNT == '0)
    else $error("service clear");
  a_vector_read: assert property (RD && ADDR == RCW_SERVICE_ADDR |=>
    RDATA == 32'(RCW_VEC_LOW))
    else $error("vector byte");
  a_monitor_holds: assert property (
    (MONITOR_MODE && (HV_ON_IRQ_PIN || HV_ON_RESET_PIN))[*3] |-> $stable(COUNT) && RESET_PIN_N)
    else $error("monitor disable");
  a_break_holds: assert property ((BREAK_STATE && HV_ON_RESET_PIN)[*3]
    |-> $stable(COUNT) && RESET_PIN_N)
    else $error("break disable");
  a_stop_holds: assert property (STOP_MODE[*3] |-> $stable(COUNT))
    else $error("stop freeze");
  c_service: cover property (WR && ADDR == RCW_SERVICE_ADDR);
  c_monitor: cover property (MONITOR_MODE && HV_ON_IRQ_PIN);
  c_stop: cover property (STOP_MODE[*3]);
  c_expire: cover property ($fell(RESET_PIN_N));
endmodule
bind rcw_top rcw_top_monitor rcw_top_monitor_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .MONITOR_MODE(MONITOR_MODE), .BREAK_STATE(BREAK_STATE), .HV_ON_RESET_PIN(HV_ON_RESET_PIN),
  .HV_ON_IRQ_PIN(HV_ON_IRQ_PIN), .STOP_MODE(STOP_MODE), .ADDR(ADDR), .WR(WR), .RD(RD),
  .RDATA(RDATA), .RESET_PIN_N(RESET_PIN_N), .RESET_PIN_OE(RESET_PIN_OE), .COUNT(COUNT));

// ### sim/rcw_top_tb.sv
/* Self-checking bench for the watchdog top.
   Assumes the checker is bound from its own file. */
`timescale 1ns/10ps
module rcw_top_tb import rcw_pkg::*; ;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic POR = 1'b1;
  logic [4:0] ctl = 5'h0; // Stop, monitor, break, hv reset, hv irq
  logic STOP_EXEC = 1'b0;
  logic VECTOR_FETCH = 1'b0;
  logic [15:0] ADDR = 16'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA, v, w;
  logic RESET_PIN_N, RESET_PIN_OE, WATCHDOG_IRQ;
  logic [5:0] COUNT;
  logic [1:0] seen;
  int err_total = 0;
  int checks_done = 0;
  int n = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  rcw_top rcw_top_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .POR(POR), .MONITOR_MODE(ctl[3]),
    .BREAK_STATE(ctl[2]), .HV_ON_RESET_PIN(ctl[1]), .HV_ON_IRQ_PIN(ctl[0]), .STOP_MODE(ctl[4]),
    .STOP_EXEC(STOP_EXEC), .VECTOR_FETCH(VECTOR_FETCH), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RESET_PIN_N(RESET_PIN_N), .RESET_PIN_OE(RESET_PIN_OE),
    .WATCHDOG_IRQ(WATCHDOG_IRQ), .COUNT(COUNT));
  task automatic ck(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge SYS_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // Count register must freeze or keep moving under the given pins
  task automatic frz(input logic [4:0] c, input logic f, input string m);
    @(posedge SYS_CLK);
    ctl <= c;
    repeat (4) @(posedge SYS_CLK);
    rd(RCW_COUNT_ADDR);
    w = v;
    repeat (300) @(posedge SYS_CLK);
    rd(RCW_COUNT_ADDR);
    ck((v === w) === f, m);
    @(posedge SYS_CLK);
    ctl <= 5'h0;
  endtask
  task automatic t_reset;
    rd(RCW_STATUS_ADDR);
    ck(v === 32'h0, "status reset");
    rd(RCW_CONFIG_ADDR);
    ck(v === 32'(RCW_CFG_RESET), "config reset");
    rd(16'h0020);
    ck(v === 32'h0, "unmapped read");
    rd(RCW_SERVICE_ADDR);
    ck(v === 32'(RCW_VEC_LOW), "vector byte");
    ck(RESET_PIN_N === 1'b1 && RESET_PIN_OE === 1'b0, "pin idle");
    $display("reset test done");
  endtask
  task automatic t_service;
    repeat (400) @(posedge SYS_CLK);
    rd(RCW_COUNT_ADDR);
    ck(v > 32'h40 && v < 32'h100, "prescaler runs");
    wr(RCW_SERVICE_ADDR, 32'ha5);
    rd(RCW_COUNT_ADDR);
    ck(v < 32'h10, "service clear");
    rd(RCW_STATUS_ADDR);
    ck(v[RCW_EV_SERVICE] === 1'b1, "service event");
    wr(RCW_MASK_ADDR, 32'h0);
    rd(RCW_MASK_ADDR);
    seen[0] = WATCHDOG_IRQ;
    wr(RCW_MASK_ADDR, 32'h3);
    rd(RCW_MASK_ADDR);
    seen[1] = WATCHDOG_IRQ;
    ck(v === 32'h3 && seen === 2'b10, "mask gates irq");
    wr(RCW_STATUS_ADDR, 32'h2);
    rd(RCW_STATUS_ADDR);
    ck(v[RCW_EV_SERVICE] === 1'b0 && WATCHDOG_IRQ === 1'b0, "status clear");
    $display("service test done");
  endtask
  task automatic t_modes;
    frz(5'h09, 1'b1, "monitor hv irq");
    frz(5'h0a, 1'b1, "monitor hv reset");
    frz(5'h06, 1'b1, "break hv reset");
    frz(5'h05, 1'b0, "break hv irq");
    frz(5'h10, 1'b1, "stop mode");
    frz(5'h00, 1'b0, "running");
    wr(RCW_CONFIG_ADDR, 32'h1 << RCW_CFG_DISABLE);
    frz(5'h00, 1'b1, "option disable");
    wr(RCW_CONFIG_ADDR, 32'h1 << RCW_CFG_LONG);
    rd(RCW_CONFIG_ADDR);
    ck(v === 32'h2, "long select");
    frz(5'h00, 1'b0, "long running");
    $display("mode test done");
  endtask
  task automatic t_clears;
    for (int i = 0; i < 2; i++) begin
      repeat (500) @(posedge SYS_CLK);
      STOP_EXEC <= (i == 0);
      VECTOR_FETCH <= (i == 1);
      @(posedge SYS_CLK);
      STOP_EXEC <= 1'b0;
      VECTOR_FETCH <= 1'b0;
      rd(RCW_COUNT_ADDR);
      ck(v < 32'h4, "pulse clear");
    end
    repeat (500) @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    rd(RCW_COUNT_ADDR);
    ck(v < 32'h4, "reset clear");
    $display("clear test done");
  endtask
  // Power-on clear lands near 164 us after start
  task automatic t_por;
    while ($time < 170_000) @(posedge SYS_CLK);
    rd(RCW_COUNT_ADDR);
    ck(v < 32'h100, "power-on clear");
    $display("power-on test done");
  endtask
  task automatic t_expire;
    wr(RCW_CONFIG_ADDR, 32'h0);
    wr(RCW_SERVICE_ADDR, 32'h0);
    repeat (20000) @(negedge SYS_CLK);
    ck(COUNT === 6'h1, "counter carry");
    wr(RCW_SERVICE_ADDR, 32'hff);
    rd(RCW_COUNT_ADDR);
    ck(v < 32'h20, "counter service");
    n = 0;
    while (RESET_PIN_N === 1'b1 && n < 40000) begin
      @(negedge SYS_CLK);
      n++;
    end
    ck(n >= 32600 && n <= 32800, "short period");
    ck(RESET_PIN_OE === 1'b1, "pin driven");
    n = 0;
    while (RESET_PIN_N === 1'b0 && n < 1000) begin
      @(negedge SYS_CLK);
      n++;
    end
    ck(n >= 126 && n <= 132, "pulse length");
    rd(RCW_CAUSE_ADDR);
    ck(v === 32'h1, "cause set");
    rd(RCW_CAUSE_ADDR);
    ck(v === 32'h0, "cause read clear");
    rd(RCW_STATUS_ADDR);
    ck(v[RCW_EV_EXPIRE] === 1'b1, "expire event");
    $display("expiry test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    POR <= 1'b0;
    t_reset;
    t_service;
    t_modes;
    t_clears;
    t_por;
    t_expire;
    tally_and_finish;
  end
  initial begin
    #1_000_000;
    err_total++;
    $display("FAIL %0t hang", $time);
    tally_and_finish;
  end
endmodule
